// >>> hw/hdlc_rx_defines.svh
// Purpose: constants of the receive buffer controller
// Assumes: included by bare name, definitions only
// Notes: sizes in bytes, positions in bits
`ifndef HDLC_RX_DEFINES_SVH
`define HDLC_RX_DEFINES_SVH

// ****************************************
// store and queue geometry
// ****************************************
`define RX_DEPTH 64
`define RX_AW 6
`define RX_PW 7
`define RX_USED_FULL 7'h40
`define RX_DATA_LIMIT 7'h3F
`define Q_AW 6
`define Q_PW 7
`define Q_DEPTH 64
`define Q_W 20

// ****************************************
// block size selector
// ****************************************
`define SEL_RST 2'h0
`define BLK_MAX 7'h20

// ****************************************
// appended status byte fields
// ****************************************
`define STA_VALID_BIT 7
`define STA_LOST_BIT 6
`define STA_CRC_BIT 5
`define STA_ABORT_BIT 4

// ****************************************
// count registers
// ****************************************
`define CNT_W 12
`define CNT_MAX 12'hFFF
`define CNT_OVF_BIT 4

`endif

// >>> hw/hdlc_rx_pkg.sv
// Purpose: types of the receive buffer controller
// Assumes: nothing
// Notes: encodings written out
package hdlc_rx_pkg;

  typedef logic [1:0] blk_sel_type;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_RECV = 2'b01,
    FR_DROP = 2'b10
  } frame_state_type;

  typedef enum logic {
    EV_POOL = 1'b0,
    EV_END = 1'b1
  } event_kind_type;

endpackage : hdlc_rx_pkg

// >>> hw/rx_event_queue.sv
// Purpose: wait line of pending block and frame-end indications
// Assumes: each entry owns at least one stored byte, so it cannot overflow
// Notes: head is read combinationally, popped by the owner
`include "hdlc_rx_defines.svh"

module rx_event_queue (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [`Q_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [`Q_W-1:0] head_o,
  output logic empty_o
);
  import hdlc_rx_pkg::*;

  logic [`Q_W-1:0] slot [0:`Q_DEPTH-1];
  logic [`Q_PW-1:0] wr_ptr;
  logic [`Q_PW-1:0] rd_ptr;

  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && push_i && !flush_i) begin
      slot[wr_ptr[`Q_AW-1:0]] <= push_data_i;
    end
  end

  // flush wins: a push in the reset cycle is part of the discarded data
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
    end else if (clk_en_i) begin
      if (flush_i) begin
        wr_ptr <= 7'h00;
        rd_ptr <= 7'h00;
      end else begin
        if (push_i) begin
          wr_ptr <= wr_ptr + 7'h01;
        end
        if (pop_i && !empty_o) begin
          rd_ptr <= rd_ptr + 7'h01;
        end
      end
    end
  end

  assign empty_o = (wr_ptr == rd_ptr);
  assign head_o = slot[rd_ptr[`Q_AW-1:0]];

endmodule : rx_event_queue

// >>> hw/hdlc_receive_fifo.sv
// Purpose: receive buffer controller of an hdlc unit
// Assumes: framing logic and host logic on core_clk_i, no synchronisers
// Notes: host sees one block at a time, queued events follow on ack
`include "hdlc_rx_defines.svh"

module hdlc_receive_fifo (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // receive side, from the framing logic
  input wire logic rx_frame_start_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_frame_end_i,
  input wire logic rx_crc_ok_i,
  input wire logic rx_valid_frame_i,
  input wire logic rx_abort_i,
  // host side
  input wire logic sel_wr_i,
  input wire hdlc_rx_pkg::blk_sel_type sel_data_i,
  input wire logic rx_block_ack_i,
  input wire logic rx_reset_cmd_i,
  input wire logic data_rd_i,
  input wire logic irq_status_rd_i,
  output hdlc_rx_pkg::blk_sel_type rx_block_size_sel_o,
  output logic [7:0] data_o,
  output logic rx_pool_full_o,
  output logic rx_message_end_o,
  output logic rx_frame_overflow_o,
  output logic irq_o,
  output logic [7:0] rx_count_low_o,
  output logic [7:0] rx_count_high_o
);
  import hdlc_rx_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] store [0:`RX_DEPTH-1];
  logic [`RX_PW-1:0] wr_ptr;
  logic [`RX_PW-1:0] rel_ptr;
  logic [`RX_PW-1:0] used;
  blk_sel_type sel;
  logic [6:0] act_size;
  frame_state_type fstate;
  logic [6:0] blk_cnt;
  logic [`CNT_W-1:0] frame_cnt;
  logic frame_ovf;
  logic frame_lost;
  logic is_status;
  logic data_ok;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] sta_byte;
  logic [6:0] next_blk;
  logic [`CNT_W-1:0] next_cnt;
  logic next_ovf;
  logic push;
  logic [`Q_W-1:0] push_data;
  logic [`Q_W-1:0] head;
  logic q_empty;
  logic pop;
  logic present;
  event_kind_type cur_kind;
  logic [5:0] cur_len;
  logic [5:0] rd_off;
  logic [5:0] next_off;
  logic [`RX_AW-1:0] rd_addr;
  logic [5:0] head_len;

  // ****************************************
  // write path
  // ****************************************
  assign used = wr_ptr - rel_ptr;
  // frame end cycle carries no data byte, it writes the status byte
  assign is_status = (fstate == FR_RECV) && rx_frame_end_i;
  // one slot is kept back so the status byte always fits
  assign data_ok = (fstate == FR_RECV) && rx_byte_valid_i &&
                   !rx_frame_end_i && (used < `RX_DATA_LIMIT);
  assign wr_en = data_ok || (is_status && (used < `RX_USED_FULL));

  always_comb begin
    sta_byte = 8'h00;
    sta_byte[`STA_VALID_BIT] = rx_valid_frame_i;
    sta_byte[`STA_LOST_BIT] = frame_lost;
    sta_byte[`STA_CRC_BIT] = rx_crc_ok_i;
    sta_byte[`STA_ABORT_BIT] = rx_abort_i;
  end

  assign wr_byte = is_status ? sta_byte : rx_byte_i;
  assign next_blk = blk_cnt + 7'h01;
  assign next_cnt = frame_cnt + 12'h001;
  assign next_ovf = frame_ovf || (frame_cnt == `CNT_MAX);

  // a full data block always has the status byte behind it, so the
  // frame is known to be longer than the block at this point
  assign push = wr_en && (is_status || (next_blk >= act_size));
  assign push_data = {is_status ? EV_END : EV_POOL,
                      next_blk[5:0], next_ovf, next_cnt};

  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && wr_en) begin
      store[wr_ptr[`RX_AW-1:0]] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= 7'h00;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i) begin
        wr_ptr <= 7'h00;
      end else if (wr_en) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
    end
  end

  // ****************************************
  // frame tracking
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fstate <= FR_IDLE;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i) begin
        fstate <= FR_IDLE;
      end else if (rx_frame_start_i) begin
        if (used >= `RX_DATA_LIMIT) begin
          fstate <= FR_DROP;
        end else begin
          fstate <= FR_RECV;
        end
      end else if (rx_frame_end_i) begin
        fstate <= FR_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      blk_cnt <= 7'h00;
      frame_cnt <= 12'h000;
      frame_ovf <= 1'b0;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i || rx_frame_start_i) begin
        blk_cnt <= 7'h00;
        frame_cnt <= 12'h000;
        frame_ovf <= 1'b0;
      end else if (wr_en) begin
        frame_cnt <= next_cnt;
        frame_ovf <= next_ovf;
        if (push) begin
          blk_cnt <= 7'h00;
        end else begin
          blk_cnt <= next_blk;
        end
      end
    end
  end

  // lost data bytes are counted nowhere, only flagged
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      frame_lost <= 1'b0;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i || rx_frame_start_i) begin
        frame_lost <= 1'b0;
      end else if ((fstate == FR_RECV) && rx_byte_valid_i &&
                   !rx_frame_end_i && !data_ok) begin
        frame_lost <= 1'b1;
      end
    end
  end

  // ****************************************
  // block size
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sel <= `SEL_RST;
    end else if (clk_en_i && sel_wr_i) begin
      sel <= sel_data_i;
    end
  end

  // the running block keeps its size until the next ack, block presented or not, or a receiver reset
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      act_size <= `BLK_MAX;
    end else if (clk_en_i) begin
      if (rx_block_ack_i || rx_reset_cmd_i) begin
        act_size <= `BLK_MAX >> sel;
      end
    end
  end

  assign rx_block_size_sel_o = sel;

  // ****************************************
  // indication queue
  // ****************************************
  assign pop = !present && !q_empty;
  assign head_len = head[`Q_W-2 -: 6];

  rx_event_queue u_queue (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .flush_i(rx_reset_cmd_i),
    .push_i(push),
    .push_data_i(push_data),
    .pop_i(pop),
    .head_o(head),
    .empty_o(q_empty)
  );

  // ****************************************
  // presented block
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      present <= 1'b0;
      cur_kind <= EV_POOL;
      cur_len <= 6'h00;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i) begin
        present <= 1'b0;
      end else if (present && rx_block_ack_i) begin
        present <= 1'b0;
      end else if (pop) begin
        present <= 1'b1;
        cur_kind <= event_kind_type'(head[`Q_W-1]);
        cur_len <= head_len;
      end
    end
  end

  // the block space is released whether read or not
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rel_ptr <= 7'h00;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i) begin
        rel_ptr <= 7'h00;
      end else if (present && rx_block_ack_i) begin
        rel_ptr <= rel_ptr + {1'b0, cur_len};
      end
    end
  end

  // ****************************************
  // host data port
  // ****************************************
  assign rd_addr = rel_ptr[`RX_AW-1:0] + rd_off;
  assign next_off = (rd_off + 6'h01 == cur_len) ? 6'h00 : rd_off + 6'h01;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rd_off <= 6'h00;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i || rx_block_ack_i) begin
        rd_off <= 6'h00;
      end else if (data_rd_i && present) begin
        rd_off <= next_off;
      end
    end
  end

  // no pending block: data is whatever sits there, nothing moves
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      data_o <= 8'h00;
    end else if (clk_en_i && data_rd_i) begin
      data_o <= store[rd_addr];
    end
  end

  // ****************************************
  // count registers
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_count_low_o <= 8'h00;
      rx_count_high_o <= 8'h00;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i) begin
        rx_count_low_o <= 8'h00;
        rx_count_high_o <= 8'h00;
      end else if (present && rx_block_ack_i && (cur_kind == EV_END)) begin
        rx_count_low_o <= 8'h00;
        rx_count_high_o <= 8'h00;
      end else if (pop) begin
        // low bits below the block size give the last block length
        rx_count_low_o <= head[7:0];
        rx_count_high_o <= {3'h0, head[`CNT_W], head[11:8]};
      end
    end
  end

  // ****************************************
  // status bits and interrupt
  // ****************************************
  // a set in the read cycle survives the clear
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_pool_full_o <= 1'b0;
      rx_message_end_o <= 1'b0;
    end else if (clk_en_i) begin
      if (rx_reset_cmd_i) begin
        rx_pool_full_o <= 1'b0;
        rx_message_end_o <= 1'b0;
      end else if (pop) begin
        if (head[`Q_W-1] == EV_END) begin
          rx_message_end_o <= 1'b1;
          rx_pool_full_o <= rx_pool_full_o && !irq_status_rd_i;
        end else begin
          rx_pool_full_o <= 1'b1;
          rx_message_end_o <= rx_message_end_o && !irq_status_rd_i;
        end
      end else if (irq_status_rd_i) begin
        rx_pool_full_o <= 1'b0;
        rx_message_end_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_frame_overflow_o <= 1'b0;
    end else if (clk_en_i) begin
      if (rx_frame_start_i && !rx_reset_cmd_i &&
          (used >= `RX_DATA_LIMIT)) begin
        rx_frame_overflow_o <= 1'b1;
      end else if (irq_status_rd_i || rx_reset_cmd_i) begin
        rx_frame_overflow_o <= 1'b0;
      end
    end
  end

  // one cycle behind the status bits, kept registered
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= rx_pool_full_o || rx_message_end_o ||
               rx_frame_overflow_o;
    end
  end

endmodule : hdlc_receive_fifo

// >>> sim/hdlc_receive_fifo_sva.sv
// Purpose: port checker of the receive buffer controller
// Assumes: bound to hdlc_receive_fifo, one clock domain
// Notes: clk_en_i low freezes the block
module hdlc_receive_fifo_sva (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic rx_frame_start_i,
  input wire logic rx_byte_valid_i,
  input wire logic rx_frame_end_i,
  input wire logic sel_wr_i,
  input wire hdlc_rx_pkg::blk_sel_type sel_data_i,
  input wire logic rx_block_ack_i,
  input wire logic rx_reset_cmd_i,
  input wire logic data_rd_i,
  input wire logic irq_status_rd_i,
  input wire hdlc_rx_pkg::blk_sel_type rx_block_size_sel_o,
  input wire logic [7:0] data_o,
  input wire logic rx_pool_full_o,
  input wire logic rx_message_end_o,
  input wire logic rx_frame_overflow_o,
  input wire logic irq_o,
  input wire logic [7:0] rx_count_low_o,
  input wire logic [7:0] rx_count_high_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import hdlc_rx_pkg::*;
  // *****
  // assertions
  // *****
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_sel_reset_value: assert property (disable iff (1'b0)
    !reset_n_i |=> rx_block_size_sel_o == 2'h0)
    else $error("selector not at 32-byte value after reset");
  a_sel_write_seen: assert property (
    clk_en_i && sel_wr_i |=> rx_block_size_sel_o == $past(sel_data_i))
    else $error("selector write lost");
  a_irq_follows_bits: assert property ($past(clk_en_i) |->
    irq_o == $past(rx_pool_full_o | rx_message_end_o | rx_frame_overflow_o))
    else $error("interrupt output not following status bits");
  a_pool_sticky: assert property (
    rx_pool_full_o && !irq_status_rd_i && !rx_reset_cmd_i |=> rx_pool_full_o)
    else $error("pool-full bit dropped without status read");
  a_pool_cause: assert property ($rose(rx_pool_full_o) |->
    $past(rx_byte_valid_i) || $past(rx_byte_valid_i, 2)
    || $past(rx_block_ack_i) || $past(rx_block_ack_i, 2))
    else $error("pool-full raised without byte or ack");
  a_end_cause: assert property ($rose(rx_message_end_o) |->
    $past(rx_frame_end_i) || $past(rx_frame_end_i, 2)
    || $past(rx_block_ack_i) || $past(rx_block_ack_i, 2))
    else $error("message-end raised without frame end or ack");
  a_ovf_cause: assert property ($rose(rx_frame_overflow_o) |->
    $past(rx_frame_start_i) || $past(rx_frame_start_i, 2))
    else $error("frame-overflow raised without frame start");
  a_reset_cmd_clears: assert property (
    clk_en_i && rx_reset_cmd_i |=> !rx_pool_full_o && !rx_message_end_o
    && !rx_frame_overflow_o && rx_count_low_o == 8'h00)
    else $error("receiver reset left state behind");
  a_count_top_zero: assert property (
    rx_count_high_o[7:5] == 3'h0)
    else $error("unused count bits set");
  a_data_hold: assert property (
    !$past(data_rd_i) |-> $stable(data_o))
    else $error("read data changed without a read");
endmodule : hdlc_receive_fifo_sva

// >>> sim/hdlc_host_model.sv
// Purpose: host side model, issues commands and reads the buffer
// Assumes: strobes launched at the falling edge, one cycle each
// Notes: read data taken at the edge after the strobe
module hdlc_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] data_i,
  output logic sel_wr_o,
  output hdlc_rx_pkg::blk_sel_type sel_data_o,
  output logic rx_block_ack_o,
  output logic rx_reset_cmd_o,
  output logic data_rd_o,
  output logic irq_status_rd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import hdlc_rx_pkg::*;
  logic [4:0] strobe = 5'h00;
  assign {sel_wr_o, rx_block_ack_o, rx_reset_cmd_o} = strobe[4:2];
  assign {data_rd_o, irq_status_rd_o} = strobe[1:0];
  initial sel_data_o = 2'h0;
  // *****
  // strobes: 4 sel, 3 ack, 2 reset, 1 read, 0 status
  // *****
  task automatic pulse(input int idx, input blk_sel_type s);
    @(negedge core_clk_i);
    strobe[idx] = 1'b1;
    if (idx == 4) sel_data_o = s;
    @(negedge core_clk_i);
    strobe = 5'h00;
    // released bus shows no stale value
    sel_data_o = ~sel_data_o;
  endtask : pulse
  task automatic set_mode(input blk_sel_type s);
    pulse(4, s);
    pulse(2, s);
  endtask : set_mode
  task automatic ack_block(input blk_sel_type s);
    pulse(4, s);
    pulse(3, s);
  endtask : ack_block
  task automatic read_byte(output logic [7:0] b);
    pulse(1, 2'h0);
    b = data_i;
  endtask : read_byte
endmodule : hdlc_host_model

// >>> sim/hdlc_receive_fifo_test.sv
// Purpose: self-checking bench of the receive buffer controller
// Assumes: host model drives the host side, checker bound below
// Notes: expected bytes kept in store order in one queue
module hdlc_receive_fifo_test;
  timeunit 1ns;
  timeprecision 1ns;
  import hdlc_rx_pkg::*;
  logic core_clk_i, reset_n_i, clk_en_i, rx_frame_start_i;
  logic rx_byte_valid_i, rx_frame_end_i, rx_crc_ok_i, rx_valid_frame_i;
  logic rx_abort_i, sel_wr_i, rx_block_ack_i, rx_reset_cmd_i, data_rd_i;
  logic irq_status_rd_i, irq_o, rx_pool_full_o, rx_message_end_o;
  logic rx_frame_overflow_o;
  logic [7:0] rx_byte_i, data_o, rx_count_low_o, rx_count_high_o;
  blk_sel_type sel_data_i, rx_block_size_sel_o, cur_sel;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;
  hdlc_receive_fifo u_hdlc_receive_fifo (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .rx_frame_start_i(rx_frame_start_i), .rx_byte_valid_i(rx_byte_valid_i),
    .rx_byte_i(rx_byte_i), .rx_frame_end_i(rx_frame_end_i),
    .rx_crc_ok_i(rx_crc_ok_i), .rx_valid_frame_i(rx_valid_frame_i),
    .rx_abort_i(rx_abort_i), .sel_wr_i(sel_wr_i), .sel_data_i(sel_data_i),
    .rx_block_ack_i(rx_block_ack_i), .rx_reset_cmd_i(rx_reset_cmd_i),
    .data_rd_i(data_rd_i), .irq_status_rd_i(irq_status_rd_i),
    .rx_block_size_sel_o(rx_block_size_sel_o), .data_o(data_o),
    .rx_pool_full_o(rx_pool_full_o), .rx_message_end_o(rx_message_end_o),
    .rx_frame_overflow_o(rx_frame_overflow_o), .irq_o(irq_o),
    .rx_count_low_o(rx_count_low_o), .rx_count_high_o(rx_count_high_o));
  hdlc_host_model u_hdlc_host_model (.core_clk_i(core_clk_i),
    .data_i(data_o), .sel_wr_o(sel_wr_i), .sel_data_o(sel_data_i),
    .rx_block_ack_o(rx_block_ack_i), .rx_reset_cmd_o(rx_reset_cmd_i),
    .data_rd_o(data_rd_i), .irq_status_rd_o(irq_status_rd_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // *****
  // compares and drivers
  // *****
  task automatic check_word(string what, logic [11:0] e, logic [11:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check_word
  task automatic check_flag(string what, logic e, logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : check_flag
  // status byte: valid, lost, crc, abort from the top bit down
  function automatic logic [7:0] sta_exp(logic [2:0] fl, logic lost);
    return {fl[2], lost, fl[1], fl[0], 4'h0};
  endfunction : sta_exp
  task automatic send_frame(input int len, input logic [2:0] fl);
    logic drop;
    logic lost;
    drop = exp_q.size() >= 63;
    lost = 1'b0;
    rx_frame_start_i = 1'b1;
    @(negedge core_clk_i);
    rx_frame_start_i = 1'b0;
    repeat (len) begin
      rx_byte_valid_i = 1'b1;
      rx_byte_i = 8'($urandom);
      // last slot kept for the status byte
      if (exp_q.size() < 63) exp_q.push_back(rx_byte_i);
      else lost = 1'b1;
      @(negedge core_clk_i);
    end
    rx_byte_valid_i = 1'b0;
    {rx_valid_frame_i, rx_crc_ok_i, rx_abort_i} = fl;
    rx_frame_end_i = 1'b1;
    if (!drop) exp_q.push_back(sta_exp(fl, lost));
    @(negedge core_clk_i);
    rx_frame_end_i = 1'b0;
  endtask : send_frame
  task automatic serve(input int len, input logic is_end, input int cnt);
    logic [7:0] b;
    logic [7:0] first;
    int n;
    n = 0;
    while (!(rx_pool_full_o || rx_message_end_o) && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    @(negedge core_clk_i);
    check_flag("end", is_end, rx_message_end_o);
    check_flag("pool", !is_end, rx_pool_full_o);
    check_flag("irq", 1'b1, irq_o);
    if (cnt >= 0) check_word("count", 12'(cnt),
      {rx_count_high_o[3:0], rx_count_low_o});
    u_hdlc_host_model.pulse(0, 2'h0);
    check_flag("held", 1'b0, rx_pool_full_o | rx_message_end_o);
    first = exp_q[0];
    repeat (len) begin
      u_hdlc_host_model.read_byte(b);
      check_word("data", {4'h0, exp_q.pop_front()}, {4'h0, b});
    end
    u_hdlc_host_model.read_byte(b);
    check_word("wrap", {4'h0, first}, {4'h0, b});
    u_hdlc_host_model.ack_block(cur_sel);
    if (is_end) check_word("cleared", 12'h000,
      {rx_count_high_o[3:0], rx_count_low_o});
    else if (cnt >= 0) check_word("kept", 12'(cnt),
      {rx_count_high_o[3:0], rx_count_low_o});
  endtask : serve
  task automatic serve_frame(input int t, input int blk);
    int rem;
    rem = t;
    while (rem > blk) begin
      serve(blk, 1'b0, t - rem + blk);
      rem -= blk;
    end
    serve(rem, 1'b1, t);
  endtask : serve_frame
  task automatic end_sim();
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (30000) @(posedge core_clk_i);
    n_errors++;
    end_sim();
  end
  // *****
  // scenarios
  // *****
  initial begin
    int blk;
    int len;
    {rx_frame_start_i, rx_byte_valid_i, rx_frame_end_i} = 3'h0;
    {rx_crc_ok_i, rx_valid_frame_i, rx_abort_i} = 3'h0;
    rx_byte_i = 8'h00;
    reset_n_i = 1'b0;
    clk_en_i = 1'b1;
    cur_sel = 2'h3;
    void'($urandom(32'h5CE0));
    repeat (12) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    check_word("sel", 12'h000, {10'h000, rx_block_size_sel_o});
    // a write alone must leave the 32-byte threshold active
    u_hdlc_host_model.pulse(4, 2'h3);
    repeat (3) u_hdlc_host_model.pulse(1, 2'h0);
    send_frame(6, 3'h5);
    serve_frame(7, 32);
    for (int s = 0; s < 4; s++) begin
      cur_sel = 2'(s);
      blk = 32 >> s;
      u_hdlc_host_model.set_mode(cur_sel);
      len = 1 + int'($urandom % (62 - blk));
      send_frame(blk - 1, 3'($urandom));
      send_frame(len, 3'($urandom));
      serve_frame(blk, blk);
      serve_frame(len + 1, blk);
    end
    cur_sel = 2'h0;
    u_hdlc_host_model.set_mode(cur_sel);
    send_frame(64, 3'h6);
    send_frame(5, 3'h4);
    check_flag("frame_ovf", 1'b1, rx_frame_overflow_o);
    serve(32, 1'b0, 32);
    serve(32, 1'b1, -1);
    send_frame(10, 3'h5);
    repeat (3) @(negedge core_clk_i);
    clk_en_i = 1'b0;
    // a status read while frozen must not be taken
    u_hdlc_host_model.pulse(0, 2'h0);
    check_flag("frozen", 1'b1, rx_message_end_o);
    check_flag("frozen_irq", 1'b1, irq_o);
    clk_en_i = 1'b1;
    u_hdlc_host_model.set_mode(cur_sel);
    exp_q.delete();
    check_flag("flushed", 1'b0, rx_message_end_o);
    send_frame(3, 3'h1);
    serve_frame(4, 32);
    end_sim();
  end
endmodule : hdlc_receive_fifo_test
bind hdlc_receive_fifo hdlc_receive_fifo_sva u_hdlc_receive_fifo_sva (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
  .rx_frame_start_i(rx_frame_start_i), .rx_byte_valid_i(rx_byte_valid_i),
  .rx_frame_end_i(rx_frame_end_i), .sel_wr_i(sel_wr_i),
  .sel_data_i(sel_data_i), .rx_block_ack_i(rx_block_ack_i),
  .rx_reset_cmd_i(rx_reset_cmd_i), .data_rd_i(data_rd_i),
  .irq_status_rd_i(irq_status_rd_i), .data_o(data_o),
  .rx_block_size_sel_o(rx_block_size_sel_o), .irq_o(irq_o),
  .rx_pool_full_o(rx_pool_full_o), .rx_message_end_o(rx_message_end_o),
  .rx_frame_overflow_o(rx_frame_overflow_o),
  .rx_count_low_o(rx_count_low_o), .rx_count_high_o(rx_count_high_o));
